/* File: dpa_defs.vh */
`ifndef DPA_DEFS_VH
`define DPA_DEFS_VH
`define DPA_CLK_NS        20
`define DPA_ADDR_W        11
`define DPA_DATA_W        8
// slowest grade figures, in ns
`define DPA_T_WP_NS       55
`define DPA_T_WZ_NS       40
`define DPA_T_DW_NS       40
`define DPA_T_AS_NS       20
`define DPA_T_BUSY_NS     50
`define DPA_T_WH_NS       20
`define DPA_T_WDD_NS      120
`define DPA_T_BDD_NS      65
`define DPA_T_RD_NS       100
// least times round up to whole cycles
`define DPA_CYC(ns)       (((ns) + `DPA_CLK_NS - 1) / `DPA_CLK_NS)
`define DPA_N_SETUP       `DPA_CYC(`DPA_T_AS_NS + `DPA_T_BUSY_NS)
`define DPA_N_WZ          `DPA_CYC(`DPA_T_WZ_NS)
`define DPA_N_WP          `DPA_CYC(`DPA_T_WP_NS)
`define DPA_N_DW          `DPA_CYC(`DPA_T_DW_NS)
`define DPA_N_WH          `DPA_CYC(`DPA_T_WH_NS)
`define DPA_N_RD          `DPA_CYC(`DPA_T_RD_NS + `DPA_T_BDD_NS)
`define DPA_CNT_W         4
`endif

/* File: dpa_port.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.vh"
// one host port sequencer: drives select, strobe, address and data pins
module dpa_port (
    input  wire                     i_sys_clk,
    input  wire                     i_nrst,
    input  wire                     i_req,      // start an access, sampled only in idle; drop it once select is low
    input  wire                     i_wr,       // 1 write, 0 read
    input  wire [`DPA_ADDR_W-1:0]   i_addr,
    input  wire [`DPA_DATA_W-1:0]   i_wdata,
    input  wire                     i_block_n,  // busy flag from the device, low = blocked
    input  wire [`DPA_DATA_W-1:0]   i_dq_in,
    output reg                      o_sel_n,
    output reg                      o_we_n,
    output reg                      o_oe_n,
    output reg  [`DPA_ADDR_W-1:0]   o_addr,
    output reg  [`DPA_DATA_W-1:0]   o_dq_out,
    output reg                      o_dq_oe_n,  // low while driving data
    output reg  [`DPA_DATA_W-1:0]   o_rdata,
    output reg                      o_done,     // one-cycle pulse
    output reg                      o_blocked   // pulse: access saw busy
);
    // one-hot states
    localparam [5:0] S_IDLE = 6'h01, S_SETUP = 6'h02, S_WZ = 6'h04,
                     S_PULSE = 6'h08, S_HOLD = 6'h10, S_READ = 6'h20;
    reg [5:0]            state_r;
    reg [`DPA_CNT_W-1:0] cnt_r;      // cycles left in current phase
    reg                  saw_blk_r;  // busy seen during this access

    // load a phase length
    function [`DPA_CNT_W-1:0] len;
        input integer n;
        len = n[`DPA_CNT_W-1:0];
    endfunction

    // main sequencer
    always @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            state_r   <= S_IDLE;
            cnt_r     <= {`DPA_CNT_W{1'b0}};
            saw_blk_r <= 1'b0;
            o_sel_n   <= 1'b1;
            o_we_n    <= 1'b1;
            o_oe_n    <= 1'b1;
            o_addr    <= {`DPA_ADDR_W{1'b0}};
            o_dq_out  <= {`DPA_DATA_W{1'b0}};
            o_dq_oe_n <= 1'b1;
            o_rdata   <= {`DPA_DATA_W{1'b0}};
            o_done    <= 1'b0;
            o_blocked <= 1'b0;
        end else begin
            o_done    <= 1'b0;
            o_blocked <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    if (i_req) begin
                        o_addr    <= i_addr;
                        o_dq_out  <= i_wdata;
                        o_sel_n   <= 1'b0;
                        // oe kept high on writes so outputs never fight us
                        o_oe_n    <= i_wr;
                        saw_blk_r <= 1'b0;
                        cnt_r     <= len(`DPA_N_SETUP);
                        state_r   <= S_SETUP;
                    end
                end
                S_SETUP: begin
                    // busy settles first: address and select stand before strobe
                    if (cnt_r > 1) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else if (o_oe_n) begin
                        o_we_n  <= 1'b0;
                        cnt_r   <= len(`DPA_N_WZ);
                        state_r <= S_WZ;
                    end else begin
                        cnt_r   <= len(`DPA_N_RD);
                        state_r <= S_READ;
                    end
                end
                S_WZ: begin
                    if (cnt_r > 1) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        o_dq_oe_n <= 1'b0;
                        cnt_r     <= len(`DPA_N_WP);
                        state_r   <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    if (!i_block_n) begin
                        saw_blk_r <= 1'b1;
                    end
                    if (!i_block_n) begin
                        cnt_r <= len(`DPA_N_WH);
                    end else if (cnt_r > 1) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        o_we_n  <= 1'b1;
                        cnt_r   <= len(1);
                        state_r <= S_HOLD;
                    end
                end
                S_HOLD: begin
                    // data held one cycle past strobe rise, then release
                    o_dq_oe_n <= 1'b1;
                    o_sel_n   <= 1'b1;
                    o_done    <= 1'b1;
                    o_blocked <= saw_blk_r;
                    state_r   <= S_IDLE;
                end
                S_READ: begin
                    // wait out busy plus data delay
                    if (!i_block_n) begin
                        saw_blk_r <= 1'b1;
                        cnt_r     <= len(`DPA_N_RD);
                    end else if (cnt_r > 1) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        o_rdata   <= i_dq_in;
                        o_sel_n   <= 1'b1;
                        o_oe_n    <= 1'b1;
                        o_done    <= 1'b1;
                        o_blocked <= saw_blk_r;
                        state_r   <= S_IDLE;
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: dpa_host.v */
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.vh"
// two independent hosts for the left and right ports of the dual-port ram
module dpa_host (
    input  wire                     i_sys_clk,
    input  wire                     i_nrst,
    input  wire                     i_l_req,
    input  wire                     i_l_wr,
    input  wire [`DPA_ADDR_W-1:0]   i_l_addr,
    input  wire [`DPA_DATA_W-1:0]   i_l_wdata,
    input  wire                     i_left_block_flag_n,
    input  wire [`DPA_DATA_W-1:0]   i_l_dq,
    output wire                     o_l_sel_n,
    output wire                     o_l_we_n,
    output wire                     o_l_oe_n,
    output wire [`DPA_ADDR_W-1:0]   o_l_addr,
    output wire [`DPA_DATA_W-1:0]   o_l_dq,
    output wire                     o_l_dq_oe_n,
    output wire [`DPA_DATA_W-1:0]   o_l_rdata,
    output wire                     o_l_done,
    output wire                     o_l_blocked,
    input  wire                     i_r_req,
    input  wire                     i_r_wr,
    input  wire [`DPA_ADDR_W-1:0]   i_r_addr,
    input  wire [`DPA_DATA_W-1:0]   i_r_wdata,
    input  wire                     i_right_block_flag_n,
    input  wire [`DPA_DATA_W-1:0]   i_r_dq,
    output wire                     o_r_sel_n,
    output wire                     o_r_we_n,
    output wire                     o_r_oe_n,
    output wire [`DPA_ADDR_W-1:0]   o_r_addr,
    output wire [`DPA_DATA_W-1:0]   o_r_dq,
    output wire                     o_r_dq_oe_n,
    output wire [`DPA_DATA_W-1:0]   o_r_rdata,
    output wire                     o_r_done,
    output wire                     o_r_blocked
);
    // left port sequencer; all outputs come from its flip-flops
    dpa_port u_left (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_req     (i_l_req),
        .i_wr      (i_l_wr),
        .i_addr    (i_l_addr),
        .i_wdata   (i_l_wdata),
        .i_block_n (i_left_block_flag_n),
        .i_dq_in   (i_l_dq),
        .o_sel_n   (o_l_sel_n),
        .o_we_n    (o_l_we_n),
        .o_oe_n    (o_l_oe_n),
        .o_addr    (o_l_addr),
        .o_dq_out  (o_l_dq),
        .o_dq_oe_n (o_l_dq_oe_n),
        .o_rdata   (o_l_rdata),
        .o_done    (o_l_done),
        .o_blocked (o_l_blocked)
    );
    // right port sequencer, independent of the left
    dpa_port u_right (
        .i_sys_clk (i_sys_clk),
        .i_nrst    (i_nrst),
        .i_req     (i_r_req),
        .i_wr      (i_r_wr),
        .i_addr    (i_r_addr),
        .i_wdata   (i_r_wdata),
        .i_block_n (i_right_block_flag_n),
        .i_dq_in   (i_r_dq),
        .o_sel_n   (o_r_sel_n),
        .o_we_n    (o_r_we_n),
        .o_oe_n    (o_r_oe_n),
        .o_addr    (o_r_addr),
        .o_dq_out  (o_r_dq),
        .o_dq_oe_n (o_r_dq_oe_n),
        .o_rdata   (o_r_rdata),
        .o_done    (o_r_done),
        .o_blocked (o_r_blocked)
    );
endmodule
`default_nettype wire

/* File: dpa_chk_checker.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpa_defs.vh"
// host pin discipline, seen only at the host's own ports
module dpa_chk (
    input wire logic                   i_sys_clk,
    input wire logic                   i_nrst,
    input wire logic [`DPA_ADDR_W-1:0] o_l_addr,
    input wire logic                   o_l_sel_n,
    input wire logic                   o_l_we_n,
    input wire logic                   o_l_dq_oe_n,
    input wire logic                   o_r_sel_n,
    input wire logic                   o_r_we_n,
    input wire logic                   o_r_oe_n,
    input wire logic                   o_r_dq_oe_n,
    input wire logic                   i_right_block_flag_n
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    property p_addr; !$stable(o_l_addr) |-> (o_l_we_n && $past(o_l_we_n))
        || (o_l_sel_n && $past(o_l_sel_n)); endproperty
    a_addr: assert property (p_addr) else $error("address moved mid write");
    property p_turn; !o_r_dq_oe_n |-> o_r_oe_n && $past(o_r_oe_n); endproperty
    a_turn: assert property (p_turn) else $error("data driven into output");
    property p_pulse; $fell(o_l_we_n) |=> !o_l_we_n [*2]; endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too short");
    property p_dset; $rose(o_l_we_n) |-> $past(o_l_dq_oe_n, 2) == 1'b0; endproperty
    a_dset: assert property (p_dset) else $error("data setup short");
    property p_bset; $fell(o_r_we_n) |-> !o_r_sel_n && !$past(o_r_sel_n, 4); endproperty
    a_bset: assert property (p_bset) else $error("strobe before busy settles");
    property p_hold; $rose(o_r_we_n) |-> $past(i_right_block_flag_n); endproperty
    a_hold: assert property (p_hold) else $error("strobe released in busy");
endmodule
`default_nettype wire

/* File: dpa_ram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// master dual-port ram, index 0 left, 1 right
module dpa_ram (
    input  wire logic             i_clk,
    input  wire logic [1:0]       i_sel_n,
    input  wire logic [1:0]       i_we_n,
    input  wire logic [1:0]       i_oe_n,
    input  wire logic [1:0][10:0] i_addr,
    input  wire logic [1:0][7:0]  i_din,
    input  wire logic [1:0]       i_din_oe_n,
    output logic      [1:0][7:0]  o_dq,
    output logic      [1:0]       o_busy_n
);
    logic [7:0]      mem [0:2047]; // shared cells
    logic [1:0]      on_r;         // port already selected
    logic [1:0]      bsy_r = 0;    // set bit marks the loser
    logic [1:0][7:0] last_r;       // last byte seen on the pins
    wire match = i_sel_n == 2'b00 && i_addr[0] == i_addr[1];
    // busy pins driven, one cycle late
    assign o_busy_n = ~bsy_r;
    always @(posedge i_clk) begin
        on_r <= ~i_sel_n;
        last_r <= o_dq;
        // later port loses, tie goes left
        if (!match) bsy_r <= 2'b00;
        else if (bsy_r == 2'b00) bsy_r <= (on_r[1] && !on_r[0]) ? 2'b01 : 2'b10;
        for (int p = 0; p < 2; p++)
            if (!i_sel_n[p] && !i_we_n[p] && !bsy_r[p] && !i_din_oe_n[p])
                mem[i_addr[p]] <= i_din[p];
    end
    // data only on unblocked reads; writes, busy and released pins all toggle
    always_comb for (int p = 0; p < 2; p++)
        o_dq[p] = (!i_sel_n[p] && !i_oe_n[p] && i_we_n[p] && !bsy_r[p])
            ? mem[i_addr[p]] : ~last_r[p];
endmodule
`default_nettype wire

/* File: dpa_host_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dpa_host_tb;
    logic i_sys_clk = 0, i_nrst = 0;
    logic [1:0] req = 0, wr = 0, got_blk;
    logic [1:0][10:0] ad = 0;
    logic [1:0][7:0] wd = 0;
    logic [10:0] a;
    logic [7:0] d;
    wire [1:0] sel_n, we_n, oe_n, doe_n, done, blk, busy_n;
    wire [1:0][10:0] pa;
    wire [1:0][7:0] dqh, dqd, rd;
    int n_errors = 0, check_count = 0;
    logic [7:0] exp_mem [int]; // reference contents
    always #10 i_sys_clk = ~i_sys_clk;
    dpa_host dpa_host_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_l_req(req[0]), .i_l_wr(wr[0]), .i_l_addr(ad[0]), .i_l_wdata(wd[0]),
        .i_left_block_flag_n(busy_n[0]), .i_l_dq(dqd[0]), .o_l_sel_n(sel_n[0]),
        .o_l_we_n(we_n[0]), .o_l_oe_n(oe_n[0]), .o_l_addr(pa[0]), .o_l_dq(dqh[0]),
        .o_l_dq_oe_n(doe_n[0]), .o_l_rdata(rd[0]), .o_l_done(done[0]), .o_l_blocked(blk[0]),
        .i_r_req(req[1]), .i_r_wr(wr[1]), .i_r_addr(ad[1]), .i_r_wdata(wd[1]),
        .i_right_block_flag_n(busy_n[1]), .i_r_dq(dqd[1]), .o_r_sel_n(sel_n[1]),
        .o_r_we_n(we_n[1]), .o_r_oe_n(oe_n[1]), .o_r_addr(pa[1]), .o_r_dq(dqh[1]),
        .o_r_dq_oe_n(doe_n[1]), .o_r_rdata(rd[1]), .o_r_done(done[1]), .o_r_blocked(blk[1]));
    dpa_ram dpa_ram_inst (.i_clk(i_sys_clk), .i_sel_n(sel_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .i_addr(pa), .i_din(dqh), .i_din_oe_n(doe_n), .o_dq(dqd), .o_busy_n(busy_n));
    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t flag %h exp %h", $time, got, exp);
        end
    endtask
    // one access: request held until the select pin shows it taken, then done awaited;
    // the port is idle again in the cycle done is seen, so a request left up then is re-taken
    task automatic acc(input int p, input logic w, input logic [10:0] ta, input logic [7:0] td);
        req[p] <= 1'b1;
        wr[p] <= w;
        ad[p] <= ta;
        wd[p] <= td;
        @(posedge i_sys_clk);
        for (int k = 0; k < 4 && sel_n[p] !== 1'b0; k++) @(posedge i_sys_clk);
        cmp_flag(sel_n[p], 1'b0);
        req[p] <= 1'b0;
        for (int k = 0; k < 200 && done[p] !== 1'b1; k++) @(posedge i_sys_clk);
        cmp_flag(done[p], 1'b1);
        got_blk[p] = blk[p];
        if (w) exp_mem[ta] = td;
        else cmp_val(rd[p], exp_mem[ta]);
        @(posedge i_sys_clk);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(56220));
        repeat (12) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        @(posedge i_sys_clk);
        // random bytes written on one side, read back on both
        for (int i = 0; i < 8; i++) begin
            a = $urandom;
            d = $urandom;
            acc(i % 2, 1'b1, a, d);
            acc(1 - i % 2, 1'b0, a, 8'h00);
            acc(i % 2, 1'b0, a, 8'h00);
        end
        $display("test crossing done");
        // left selects first, so the right write stalls behind busy
        fork
            acc(0, 1'b1, 11'h5a5, 8'h3c);
            begin repeat (2) @(posedge i_sys_clk); acc(1, 1'b1, 11'h5a5, 8'hc3); end
        join
        cmp_flag(got_blk[0], 1'b0);
        cmp_flag(got_blk[1], 1'b1);
        acc(0, 1'b0, 11'h5a5, 8'h00);
        $display("test write contention done");
        // a late read on the left waits for the right write to finish
        fork
            acc(1, 1'b1, 11'h7ff, 8'h96);
            begin repeat (2) @(posedge i_sys_clk); acc(0, 1'b0, 11'h7ff, 8'h00); end
        join
        cmp_flag(got_blk[0], 1'b1);
        cmp_flag(got_blk[1], 1'b0);
        $display("test read contention done");
        wrap_up;
    end
    initial begin
        #60000;
        n_errors++;
        wrap_up;
    end
endmodule
bind dpa_host dpa_chk dpa_chk_inst (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .o_l_addr(o_l_addr), .o_l_sel_n(o_l_sel_n), .o_l_we_n(o_l_we_n),
    .o_l_dq_oe_n(o_l_dq_oe_n), .o_r_sel_n(o_r_sel_n), .o_r_we_n(o_r_we_n),
    .o_r_oe_n(o_r_oe_n), .o_r_dq_oe_n(o_r_dq_oe_n),
    .i_right_block_flag_n(i_right_block_flag_n));
`default_nettype wire
